//--- wdog_flags_cfg.svh
// constants of the watchdog restart and reset-cause flag block
// assumes inclusion by bare name from package and modules
`ifndef WDOG_FLAGS_CFG_SVH
`define WDOG_FLAGS_CFG_SVH

// register offset on the internal register port
`define WD_FLAGS_OFFSET   8'h09

// field positions inside the flags register
`define WD_FAULT_BIT      7
`define WD_SUPPLY_BIT     6
`define WD_BACKUP_BIT     5
`define WD_KEY_MSB        3
`define WD_KEY_LSB        0

// restart key and timeout codes
`define WD_RESTART_KEY    4'ha
`define WD_CODE_INVALID   5'h00
`define WD_CODE_STOP      5'h1f
`define WD_CODE_MIN       5'h01

// reset values of the flags
`define WD_FLAG_RESET     1'b0

// timebase: clock rate and watchdog resolution
`define WD_CLK_HZ         25000000
`define WD_STEP_MS        100
`define WD_STEP_CYCLES    ((`WD_CLK_HZ / 1000) * `WD_STEP_MS)

`endif

//--- wdog_flags_pkg.sv
// types shared by the watchdog restart and reset-cause flag block
// assumes the constants header is on the include path
package wdog_flags_pkg;
  `include "wdog_flags_cfg.svh"

  typedef logic [4:0] timeout_code_type;
  typedef logic [3:0] restart_key_type;
  typedef logic [7:0] reg_byte_type;
endpackage

//--- step_divider.sv
// one-cycle enable pulse every CYCLES clocks, restartable
// assumes one clock domain and an asynchronous active-high reset
`timescale 1ns/100ps
module step_divider #(
  parameter int CYCLES = 2500000
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // control
  input  wire logic clear_i,
  // enable pulse
  output logic      step_o
);
  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  logic         step_reg;
  logic         step_next;

  // next count and pulse; clear restarts a whole period
  always_comb begin
    count_next = count_reg;
    step_next  = 1'b0;
    if (clear_i) begin
      count_next = '0;
    end else if (count_reg == LAST) begin
      count_next = '0;
      step_next  = 1'b1;
    end else begin
      count_next = W'(count_reg + 1'b1);
    end
  end

  // registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= '0;
      step_reg  <= 1'b0;
    end else begin
      count_reg <= count_next;
      step_reg  <= step_next;
    end
  end

  assign step_o = step_reg;
endmodule

//--- wdog_flags.sv
// watchdog restart logic and reset-cause flags, with the flags register
// assumes a register port already decoded from the serial interface,
// supervisor levels synchronous to clk_i, and flags held by backup power
//
// Behaviour
// [R1] every watchdog timeout sets the watchdog fault flag, enabled or not.
// [R2] while the supply is below the trip voltage the supply reset flag is set.
// [R3] the two reset-cause flags are independent and may both stay set.
// [R4] at power-up a low backup supply sets the backup low flag.
// [R5] software is expected to clear the backup low flag at initialisation.
// [R6] flags are set only by hardware, held until a write of zero clears them.
// [R7] writing key 1010b to the restart field restarts the count, others do not.
// [R8] timeout is code times 100 ms, code 0 acts as 100 ms, code 31 stops it.
`timescale 1ns/100ps
`include "wdog_flags_cfg.svh"
module wdog_flags
  import wdog_flags_pkg::*;
#(
  parameter int STEP_CYCLES = `WD_STEP_CYCLES
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // register port
  input  wire logic             reg_wr_i,
  input  wire logic [7:0]       reg_addr_i,
  input  wire logic [7:0]       reg_wdata_i,
  output logic      [7:0]       reg_rdata_o,
  // supervisor inputs
  input  wire timeout_code_type timeout_select_field_i,
  input  wire logic             wdog_enable_i,
  input  wire logic             trip_voltage_low_i,
  input  wire logic             power_up_i,
  input  wire logic             backup_supply_low_i,
  // status outputs
  output logic                  watchdog_fault_flag_o,
  output logic                  supply_reset_flag_o,
  output logic                  backup_low_flag_o,
  output logic                  wdog_fault_o,
  output logic                  wdog_reset_req_o
);
  // register access decode
  logic            wr_hit;
  logic            restart;
  restart_key_type key_in;

  assign wr_hit  = reg_wr_i && (reg_addr_i == `WD_FLAGS_OFFSET);
  assign key_in  = reg_wdata_i[`WD_KEY_MSB:`WD_KEY_LSB];
  assign restart = wr_hit && (key_in == `WD_RESTART_KEY); // [R7]

  // timebase of 100 ms steps
  logic stopped;
  logic step;

  assign stopped = (timeout_select_field_i == `WD_CODE_STOP); // [R8]

  step_divider #(
    .CYCLES (STEP_CYCLES)
  ) u_step (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (restart || stopped),
    .step_o  (step)
  );

  // watchdog count in steps and timeout detection
  timeout_code_type count_reg;
  timeout_code_type count_next;
  timeout_code_type limit;
  logic [5:0]       count_inc;
  logic             fault_event;

  assign limit = (timeout_select_field_i == `WD_CODE_INVALID) ? `WD_CODE_MIN
                                                              : timeout_select_field_i; // [R8]
  assign count_inc   = {1'b0, count_reg} + 6'h01;
  assign fault_event = step && !stopped && !restart && (count_inc >= {1'b0, limit}); // [R8]

  always_comb begin
    count_next = count_reg;
    if (restart || stopped) begin
      count_next = '0; // [R7]
    end else if (fault_event) begin
      count_next = '0;
    end else if (step) begin
      count_next = count_inc[4:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  // reset-cause flags: a set in the same cycle as a clear wins
  logic wd_flag_reg;
  logic wd_flag_next;
  logic sup_flag_reg;
  logic sup_flag_next;
  logic bl_flag_reg;
  logic bl_flag_next;
  logic clr_wd;
  logic clr_sup;
  logic clr_bl;
  logic bl_event;

  assign clr_wd   = wr_hit && !reg_wdata_i[`WD_FAULT_BIT];
  assign clr_sup  = wr_hit && !reg_wdata_i[`WD_SUPPLY_BIT];
  assign clr_bl   = wr_hit && !reg_wdata_i[`WD_BACKUP_BIT];
  assign bl_event = power_up_i && backup_supply_low_i; // [R4]

  // separate next values keep the two causes independent [R3]
  always_comb begin
    wd_flag_next  = fault_event || (wd_flag_reg && !clr_wd); // [R1] [R6]
    sup_flag_next = trip_voltage_low_i || (sup_flag_reg && !clr_sup); // [R2] [R6]
    bl_flag_next  = bl_event || (bl_flag_reg && !clr_bl); // [R4] [R6]
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wd_flag_reg  <= `WD_FLAG_RESET;
      sup_flag_reg <= `WD_FLAG_RESET;
      bl_flag_reg  <= `WD_FLAG_RESET;
    end else begin
      wd_flag_reg  <= wd_flag_next;
      sup_flag_reg <= sup_flag_next;
      bl_flag_reg  <= bl_flag_next;
    end
  end

  // fault pulses: reset request only when the watchdog is enabled
  logic fault_reg;
  logic fault_next;
  logic rst_req_reg;
  logic rst_req_next;

  always_comb begin
    fault_next   = fault_event;
    rst_req_next = fault_event && wdog_enable_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fault_reg   <= 1'b0;
      rst_req_reg <= 1'b0;
    end else begin
      fault_reg   <= fault_next;
      rst_req_reg <= rst_req_next;
    end
  end

  // read data: flags in the high bits, restart field reads zero
  reg_byte_type rdata_reg;
  reg_byte_type rdata_next;

  always_comb begin
    rdata_next = 8'h00;
    if (reg_addr_i == `WD_FLAGS_OFFSET) begin
      rdata_next[`WD_FAULT_BIT]  = wd_flag_reg;
      rdata_next[`WD_SUPPLY_BIT] = sup_flag_reg;
      rdata_next[`WD_BACKUP_BIT] = bl_flag_reg;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata_o           = rdata_reg;
  assign watchdog_fault_flag_o = wd_flag_reg;
  assign supply_reset_flag_o   = sup_flag_reg;
  assign backup_low_flag_o     = bl_flag_reg;
  assign wdog_fault_o          = fault_reg;
  assign wdog_reset_req_o      = rst_req_reg;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  fault_sets_flag_a: assert property (fault_event |=> wd_flag_reg && fault_reg) // [R1]
    else $error("timeout did not set the watchdog fault flag");

  fault_ungated_a: assert property (fault_event && !wdog_enable_i
                                    |=> wd_flag_reg && !rst_req_reg) // [R1]
    else $error("disabled watchdog fault handled wrongly");

  supply_flag_a: assert property (trip_voltage_low_i |=> sup_flag_reg) // [R2]
    else $error("low supply did not set the supply reset flag");

  flags_coexist_a: assert property (wd_flag_reg && sup_flag_reg && !wr_hit
                                    |=> wd_flag_reg && sup_flag_reg) // [R3]
    else $error("reset-cause flags did not stay set together");

  backup_flag_a: assert property (power_up_i && backup_supply_low_i
                                  |=> bl_flag_reg ##1 (bl_flag_reg || $past(clr_bl))) // [R4]
    else $error("low backup at power-up not flagged");

  flag_hold_a: assert property (wd_flag_reg && !clr_wd |=> wd_flag_reg) // [R6]
    else $error("watchdog fault flag dropped without a clear");

  flag_hw_only_a: assert property (!sup_flag_reg && !trip_voltage_low_i
                                   |=> !sup_flag_reg) // [R6]
    else $error("supply reset flag set without a cause");

  key_restart_a: assert property (restart |=> count_reg == 5'h00 && !fault_reg) // [R7]
    else $error("restart key did not restart the count");

  other_key_a: assert property (wr_hit && key_in != `WD_RESTART_KEY && !step && !stopped
                                |=> $stable(count_reg)) // [R7]
    else $error("non-key write disturbed the watchdog count");

  stop_code_a: assert property (stopped |=> !fault_reg && count_reg == 5'h00) // [R8]
    else $error("stop code did not halt the watchdog");

  code_zero_a: assert property (timeout_select_field_i == 5'h00 && step && !restart
                                |=> fault_reg) // [R8]
    else $error("code zero did not time out after one step");
endmodule

//--- host_model.sv
// host processor model driving the flags register port
// assumes the block samples the port on the rising edge of clk_i
`timescale 1ns/100ps
module host_model (
  // clock
  input  wire logic       clk_i,
  // register port
  output logic            reg_wr_o,
  output logic      [7:0] reg_addr_o,
  output logic      [7:0] reg_wdata_o,
  // read marker for the bench
  output logic            rd_o
);
  // idle port at time zero
  initial begin
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
    rd_o = 1'b0;
  end

  // one write; released data shows the inverse so stale values never match
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b1;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(posedge clk_i);
    #1;
    reg_wr_o = 1'b0;
    reg_wdata_o = ~d;
  endtask

  // one read: address held for one sampling edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    #1;
    reg_addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
  endtask

  // start-up clear of all flags plus a restart key
  task automatic init_clear();
    wr(8'h09, 8'h0a);
  endtask
endmodule

//--- tb_top.sv
// self-checking bench for the watchdog restart and reset-cause flags
// assumes package, block and host model are compiled before it
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import wdog_flags_pkg::*;
  localparam int STEP = 4;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic             reg_wr, rd, rd_q, trip, pwr, bak, en, wd_f, sup_f, bl_f, fault, req;
  logic       [7:0] addr, wdata, rdata, rd_a;
  timeout_code_type code;
  reg_byte_type     exp_q[$];
  reg_byte_type     e_v;
  int               n_errors = 0;
  int               n_checks = 0;
  int               n_faults = 0;
  int               f_v;
  int               i;

  always #20 clk_i = ~clk_i;

  host_model h (.clk_i(clk_i), .reg_wr_o(reg_wr), .reg_addr_o(addr), .reg_wdata_o(wdata),
    .rd_o(rd));
  wdog_flags #(.STEP_CYCLES(STEP)) dut (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .timeout_select_field_i(code), .wdog_enable_i(en), .trip_voltage_low_i(trip),
    .power_up_i(pwr), .backup_supply_low_i(bak), .watchdog_fault_flag_o(wd_f),
    .supply_reset_flag_o(sup_f), .backup_low_flag_o(bl_f), .wdog_fault_o(fault),
    .wdog_reset_req_o(req));

  // note the expected byte, then read
  task automatic chk_rd(input logic [7:0] a, input reg_byte_type e);
    exp_q.push_back(e);
    h.rd(a);
  endtask

  task automatic end_sim();
    if (exp_q.size() != 0) n_errors++;
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // read data compared one cycle after its address; reset request follows enable
  always @(posedge clk_i) begin
    if (rd_q) begin
      e_v = exp_q.pop_front();
      `CHK("reg_rdata_o", e_v, rdata)
      if (rd_a == 8'h09) `CHK("flag outputs", e_v[7:5], {wd_f, sup_f, bl_f})
    end
    if (fault === 1'b1) begin
      n_faults++;
      `CHK("wdog_reset_req_o", en, req)
      `CHK("watchdog_fault_flag_o", 1'b1, wd_f)
    end
    rd_q <= rd;
    rd_a <= addr;
  end

  // main sequence
  initial begin
    {trip, pwr, bak, en} = 4'h0;
    code = 5'h1f;
    i = $urandom(98);
    repeat (12) @(posedge clk_i);
    #1 rst_i = 1'b0;
    chk_rd(8'h09, 8'h00);
    bak = 1'b1;
    pwr = 1'b1;
    @(posedge clk_i);
    #1 pwr = 1'b0;
    bak = 1'b0;
    chk_rd(8'h09, 8'h20);
    h.wr(8'h33, 8'h00);
    chk_rd(8'h33, 8'h00);
    chk_rd(8'h09, 8'h20);
    h.init_clear();
    chk_rd(8'h09, 8'h00);
    trip = 1'b1;
    @(posedge clk_i);
    #1 trip = 1'b0;
    h.wr(8'h09, 8'hff);
    chk_rd(8'h09, 8'h40);
    code = 5'h01;
    en = 1'($urandom_range(1, 0));
    for (i = 0; i < 6; i++) h.wr(8'h09, 8'h4a);
    chk_rd(8'h09, 8'h40);
    for (i = 0; i < 4; i++) h.wr(8'h09, 8'hc0 | 8'($urandom_range(9, 0)));
    chk_rd(8'h09, 8'hc0);
    h.init_clear();
    code = 5'h1f;
    f_v = n_faults;
    repeat (140) @(posedge clk_i);
    #1;
    `CHK("wdog_fault_o", f_v, n_faults)
    chk_rd(8'h09, 8'h00);
    code = 5'h00;
    h.init_clear();
    chk_rd(8'h09, 8'h00);
    repeat (4) @(posedge clk_i);
    chk_rd(8'h09, 8'h80);
    `CHK("wdog_fault_o", f_v + 1, n_faults)
    repeat (2) @(posedge clk_i);
    end_sim();
  end

  // hang guard
  initial begin
    #(40 * 3000);
    n_errors++;
    end_sim();
  end
endmodule
